// ### pkg/bln_defs.vh
// Register map, field positions and reset values of the balloon queue block
`ifndef BLN_DEFS_VH
`define BLN_DEFS_VH

`define BLN_OFF_REQ_PAGES     8'h00
`define BLN_OFF_REP_PAGES     8'h04
`define BLN_OFF_DEV_FEAT      8'h08
`define BLN_OFF_DRV_FEAT      8'h0c
`define BLN_OFF_STATUS        8'h10
`define BLN_OFF_CTRL          8'h14
`define BLN_OFF_STAT_SEL      8'h18
`define BLN_OFF_STAT_LO       8'h1c
`define BLN_OFF_STAT_HI       8'h20
`define BLN_OFF_STAT_INFO     8'h24
`define BLN_OFF_HELD_PAGES    8'h28

`define BLN_FEAT_NOTIFY       0
`define BLN_FEAT_REPORT_Q     1
`define BLN_FEAT_RECLAIM      2
`define BLN_FEAT_W            3

`define BLN_ST_ACK            0
`define BLN_ST_DRIVER         1
`define BLN_ST_DRIVER_OK      2
`define BLN_ST_FEATURES_OK    3
`define BLN_ST_W              4

`define BLN_CTRL_OFFER_LSB    0
`define BLN_CTRL_LEGACY       3
`define BLN_CTRL_STRICT       4
`define BLN_CTRL_STAT_REQ     5
`define BLN_CTRL_W            5

`define BLN_CTRL_RESET        5'h17
`define BLN_REP_RESET         32'h00000000

`define BLN_Q_INFLATE         2'h0
`define BLN_Q_DEFLATE         2'h1
`define BLN_Q_REPORT          2'h2

`define BLN_NUM_TAGS          10
`define BLN_TAG_SWAP_IN       16'h0000
`define BLN_TAG_SWAP_OUT      16'h0001
`define BLN_TAG_MAJOR_FAULTS  16'h0002
`define BLN_TAG_MINOR_FAULTS  16'h0003
`define BLN_TAG_UNUSED_BYTES  16'h0004
`define BLN_TAG_TOTAL_BYTES   16'h0005
`define BLN_TAG_AVAIL_BYTES   16'h0006
`define BLN_TAG_CACHE_BYTES   16'h0007
`define BLN_TAG_HUGE_OK       16'h0008
`define BLN_TAG_HUGE_FAIL     16'h0009
`define BLN_ENTRY_LAST_HALF   3'h4

`endif

// ### core/bln_vq_drain.v
// Drain of one page-number queue: forwards page numbers, then holds the descriptor for use
module bln_vq_drain (
    input wire mclk_in,
    input wire nrst_in,
    input wire word_valid_in,
    input wire [31:0] word_in,
    input wire word_last_in,
    input wire [15:0] word_desc_in,
    input wire grant_in,
    output wire word_ready_out,
    output wire pend_out,
    output wire [15:0] pend_desc_out,
    output wire pfn_valid_out,
    output wire [31:0] pfn_out,
    output wire [15:0] pfn_count_out
);

    reg pend_reg;
    reg [15:0] desc_reg;
    reg pfn_valid_reg;
    reg [31:0] pfn_reg;
    reg [15:0] count_reg;
    wire take;

    // No new words while a finished descriptor waits to be returned
    assign word_ready_out = ~pend_reg;
    assign take = word_valid_in & ~pend_reg;
    assign pend_out = pend_reg;
    assign pend_desc_out = desc_reg;
    assign pfn_valid_out = pfn_valid_reg;
    assign pfn_out = pfn_reg;
    assign pfn_count_out = count_reg;

    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pend_reg <= 1'b0;
            desc_reg <= 16'h0000;
            pfn_valid_reg <= 1'b0;
            pfn_reg <= 32'h00000000;
            count_reg <= 16'h0000;
        end else begin
            pfn_valid_reg <= take;
            if (take) begin
                pfn_reg <= word_in;
                count_reg <= word_last_in ? 16'h0000 : count_reg + 16'h0001;
            end
            if (take && word_last_in) begin
                pend_reg <= 1'b1;
                desc_reg <= word_desc_in;
            end else if (grant_in) begin
                pend_reg <= 1'b0;
            end
        end
    end

endmodule // bln_vq_drain

// ### core/bln_top.v
// Balloon device core: APB registers, negotiation, page queues and report queue
`include "bln_defs.vh"
module bln_top (
    input wire mclk_in,
    input wire nrst_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire [3:0] pstrb_in,
    output wire [31:0] prdata_out,
    output wire pready_out,
    output wire pslverr_out,
    input wire [31:0] host_req_pages_in,
    input wire avail_valid_in,
    input wire [1:0] avail_queue_in,
    input wire [31:0] avail_word_in,
    input wire avail_last_in,
    input wire [15:0] avail_desc_in,
    output wire avail_ready_out,
    output wire used_valid_out,
    output wire [1:0] used_queue_out,
    output wire [15:0] used_desc_out,
    input wire used_ready_in,
    output wire page_valid_out,
    output wire page_inflate_out,
    output wire [31:0] page_pfn_out,
    output wire [31:0] reported_pages_out,
    output wire reported_update_out,
    output wire [2:0] negotiated_out
);

    reg [31:0] prdata_reg;
    reg pslverr_reg;
    reg [31:0] rep_reg;
    reg [31:0] rep_stage_reg;
    reg rep_update_reg;
    reg [2:0] drv_feat_reg;
    reg [2:0] neg_reg;
    reg [3:0] status_reg;
    reg [4:0] ctrl_reg;
    reg [3:0] stat_sel_reg;
    reg [9:0] stat_mask_reg;
    reg [63:0] stat_mem [0:9];
    reg [63:0] val_acc_reg;
    reg [15:0] tag_reg;
    reg [2:0] half_reg;
    reg holds_reg;
    reg first_done_reg;
    reg stat_pend_reg;
    reg [15:0] stat_desc_reg;
    reg [31:0] held_pages_reg;
    reg page_valid_reg;
    reg page_inflate_reg;
    reg [31:0] page_pfn_reg;
    reg [31:0] rd_next;
    reg rd_err_next;
    reg [31:0] rep_next;
    reg [3:0] status_next;
    integer i;

    wire setup_ph = psel_in & ~penable_in;
    wire wr_ph = psel_in & penable_in & pwrite_in;
    wire [2:0] offer = ctrl_reg[`BLN_CTRL_OFFER_LSB +: `BLN_FEAT_W];
    wire legacy = ctrl_reg[`BLN_CTRL_LEGACY];
    wire report_on = neg_reg[`BLN_FEAT_REPORT_Q] & status_reg[`BLN_ST_FEATURES_OK];
    wire drv_ok = status_reg[`BLN_ST_DRIVER_OK];
    wire stat_req = wr_ph & (paddr_in == `BLN_OFF_CTRL) & pwdata_in[`BLN_CTRL_STAT_REQ];
    wire dev_reset = wr_ph & (paddr_in == `BLN_OFF_STATUS) & (pwdata_in[7:0] == 8'h00);

    // Queue steering: queue 2 is only a queue once the report feature is live
    wire to_inf = avail_valid_in & (avail_queue_in == `BLN_Q_INFLATE);
    wire to_def = avail_valid_in & (avail_queue_in == `BLN_Q_DEFLATE);
    wire to_rep = avail_valid_in & (avail_queue_in == `BLN_Q_REPORT) & report_on;
    wire inf_ready;
    wire def_ready;
    wire inf_pend;
    wire def_pend;
    wire [15:0] inf_desc;
    wire [15:0] def_desc;
    wire inf_pfn_valid;
    wire def_pfn_valid;
    wire [31:0] inf_pfn;
    wire [31:0] def_pfn;
    wire rep_ready = drv_ok & ~holds_reg;
    wire rep_take = to_rep & rep_ready;
    // Used ring return: inflate before deflate before report buffer
    wire grant_inf = inf_pend & used_ready_in;
    wire grant_def = def_pend & ~inf_pend & used_ready_in;
    wire grant_rep = stat_pend_reg & ~inf_pend & ~def_pend & used_ready_in;

    // Unroutable words (queue 3, or queue 2 without the feature) are swallowed
    assign avail_ready_out = (avail_queue_in == `BLN_Q_INFLATE) ? inf_ready :
                             (avail_queue_in == `BLN_Q_DEFLATE) ? def_ready :
                             (avail_queue_in == `BLN_Q_REPORT && report_on) ? rep_ready :
                             1'b1;

    bln_vq_drain u_inflate (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .word_valid_in(to_inf),
        .word_in(avail_word_in),
        .word_last_in(avail_last_in),
        .word_desc_in(avail_desc_in),
        .grant_in(grant_inf),
        .word_ready_out(inf_ready),
        .pend_out(inf_pend),
        .pend_desc_out(inf_desc),
        .pfn_valid_out(inf_pfn_valid),
        .pfn_out(inf_pfn),
        .pfn_count_out()
    );

    bln_vq_drain u_deflate (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .word_valid_in(to_def),
        .word_in(avail_word_in),
        .word_last_in(avail_last_in),
        .word_desc_in(avail_desc_in),
        .grant_in(grant_def),
        .word_ready_out(def_ready),
        .pend_out(def_pend),
        .pend_desc_out(def_desc),
        .pfn_valid_out(def_pfn_valid),
        .pfn_out(def_pfn),
        .pfn_count_out()
    );

    assign used_valid_out = inf_pend | def_pend | stat_pend_reg;
    assign used_queue_out = inf_pend ? `BLN_Q_INFLATE :
                            def_pend ? `BLN_Q_DEFLATE : `BLN_Q_REPORT;
    assign used_desc_out = inf_pend ? inf_desc : def_pend ? def_desc : stat_desc_reg;

    assign prdata_out = prdata_reg;
    assign pready_out = 1'b1;
    assign pslverr_out = pslverr_reg & psel_in & penable_in;
    assign page_valid_out = page_valid_reg;
    assign page_inflate_out = page_inflate_reg;
    assign page_pfn_out = page_pfn_reg;
    assign reported_pages_out = rep_reg;
    assign reported_update_out = rep_update_reg;
    assign negotiated_out = neg_reg;

    // Read data is latched in the setup cycle so the access cycle needs no wait
    always @* begin
        rd_next = 32'h00000000;
        rd_err_next = 1'b0;
        if (paddr_in == `BLN_OFF_REQ_PAGES) begin
            rd_next = host_req_pages_in;
        end else if (paddr_in == `BLN_OFF_REP_PAGES) begin
            rd_next = rep_reg;
        end else if (paddr_in == `BLN_OFF_DEV_FEAT) begin
            rd_next = {29'h00000000, offer};
        end else if (paddr_in == `BLN_OFF_DRV_FEAT) begin
            rd_next = {29'h00000000, drv_feat_reg};
        end else if (paddr_in == `BLN_OFF_STATUS) begin
            rd_next = {28'h0000000, status_reg};
        end else if (paddr_in == `BLN_OFF_CTRL) begin
            rd_next = {27'h0000000, ctrl_reg[4:0]};
        end else if (paddr_in == `BLN_OFF_STAT_SEL) begin
            rd_next = {28'h0000000, stat_sel_reg};
        end else if (paddr_in == `BLN_OFF_STAT_LO) begin
            if (stat_sel_reg < 4'ha) begin
                rd_next = stat_mem[stat_sel_reg][31:0];
            end
        end else if (paddr_in == `BLN_OFF_STAT_HI) begin
            if (stat_sel_reg < 4'ha) begin
                rd_next = stat_mem[stat_sel_reg][63:32];
            end
        end else if (paddr_in == `BLN_OFF_STAT_INFO) begin
            rd_next = {19'h00000, first_done_reg, stat_pend_reg, holds_reg, stat_mask_reg};
        end else if (paddr_in == `BLN_OFF_HELD_PAGES) begin
            rd_next = held_pages_reg;
        end else begin
            rd_err_next = 1'b1;
        end
    end

    // Byte lane 0 is always the least significant byte, legacy or not
    always @* begin
        rep_next = rep_stage_reg;
        if (pstrb_in[0]) rep_next[7:0] = pwdata_in[7:0];
        if (pstrb_in[1]) rep_next[15:8] = pwdata_in[15:8];
        if (pstrb_in[2]) rep_next[23:16] = pwdata_in[23:16];
        if (pstrb_in[3]) rep_next[31:24] = pwdata_in[31:24];
    end

    // A driver that declined the notify bit is refused when strict mode asks for it
    always @* begin
        status_next = pwdata_in[3:0];
        if (pwdata_in[`BLN_ST_FEATURES_OK] && ctrl_reg[`BLN_CTRL_STRICT] &&
            offer[`BLN_FEAT_NOTIFY] && !drv_feat_reg[`BLN_FEAT_NOTIFY]) begin
            status_next[`BLN_ST_FEATURES_OK] = 1'b0;
        end
    end

    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
            rep_reg <= `BLN_REP_RESET;
            rep_stage_reg <= `BLN_REP_RESET;
            rep_update_reg <= 1'b0;
            drv_feat_reg <= 3'h0;
            neg_reg <= 3'h0;
            status_reg <= 4'h0;
            ctrl_reg <= `BLN_CTRL_RESET;
            stat_sel_reg <= 4'h0;
        end else begin
            rep_update_reg <= 1'b0;
            if (setup_ph) begin
                prdata_reg <= rd_next;
                pslverr_reg <= rd_err_next;
            end
            if (wr_ph) begin
                if (paddr_in == `BLN_OFF_REP_PAGES) begin
                    rep_stage_reg <= rep_next;
                    // Legacy updates that leave out byte lane 3 are staged, not published
                    if (!legacy || pstrb_in[3]) begin
                        rep_reg <= rep_next;
                        rep_update_reg <= 1'b1;
                    end
                end else if (paddr_in == `BLN_OFF_DRV_FEAT) begin
                    drv_feat_reg <= pwdata_in[2:0] & offer;
                end else if (paddr_in == `BLN_OFF_STATUS) begin
                    status_reg <= status_next;
                    if (status_next[`BLN_ST_FEATURES_OK]) begin
                        neg_reg <= drv_feat_reg;
                    end
                    if (dev_reset) begin
                        neg_reg <= 3'h0;
                        drv_feat_reg <= 3'h0;
                    end
                end else if (paddr_in == `BLN_OFF_CTRL) begin
                    ctrl_reg <= pwdata_in[4:0];
                end else if (paddr_in == `BLN_OFF_STAT_SEL) begin
                    stat_sel_reg <= pwdata_in[3:0];
                end
            end
        end
    end

    // Page number output and balloon occupancy
    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            page_valid_reg <= 1'b0;
            page_inflate_reg <= 1'b0;
            page_pfn_reg <= 32'h00000000;
            held_pages_reg <= 32'h00000000;
        end else begin
            page_valid_reg <= inf_pfn_valid | def_pfn_valid;
            if (inf_pfn_valid) begin
                page_inflate_reg <= 1'b1;
                page_pfn_reg <= inf_pfn;
                held_pages_reg <= held_pages_reg + 32'h00000001;
            end else if (def_pfn_valid) begin
                page_inflate_reg <= 1'b0;
                page_pfn_reg <= def_pfn;
                if (held_pages_reg != 32'h00000000) begin
                    held_pages_reg <= held_pages_reg - 32'h00000001;
                end
            end
            if (dev_reset) begin
                held_pages_reg <= 32'h00000000;
            end
        end
    end

    // Report queue: one buffer is parsed as it arrives and then held
    always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            val_acc_reg <= 64'h0000000000000000;
            tag_reg <= 16'h0000;
            half_reg <= 3'h0;
            holds_reg <= 1'b0;
            first_done_reg <= 1'b0;
            stat_pend_reg <= 1'b0;
            stat_desc_reg <= 16'h0000;
            stat_mask_reg <= 10'h000;
            for (i = 0; i < `BLN_NUM_TAGS; i = i + 1) begin
                stat_mem[i] <= 64'h0000000000000000;
            end
        end else begin
            if (rep_take) begin
                if (half_reg == 3'h0) begin
                    tag_reg <= avail_word_in[15:0];
                end else begin
                    val_acc_reg[16 * (half_reg - 3'h1) +: 16] <= avail_word_in[15:0];
                end
                half_reg <= (half_reg == `BLN_ENTRY_LAST_HALF || avail_last_in) ?
                            3'h0 : half_reg + 3'h1;
                // Complete entry with a known tag lands, except in legacy mode before the first buffer is done; unknown tags fall through
                if (half_reg == `BLN_ENTRY_LAST_HALF && tag_reg < 16'h000a &&
                    !(legacy && !first_done_reg)) begin
                    stat_mem[tag_reg[3:0]] <= {avail_word_in[15:0], val_acc_reg[47:0]};
                    stat_mask_reg[tag_reg[3:0]] <= 1'b1;
                end
                if (avail_last_in) begin
                    holds_reg <= 1'b1;
                    stat_desc_reg <= avail_desc_in;
                    first_done_reg <= 1'b1;
                end
            end
            if (stat_req && holds_reg && !stat_pend_reg) begin
                stat_pend_reg <= 1'b1;
            end else if (grant_rep) begin
                stat_pend_reg <= 1'b0;
                holds_reg <= 1'b0;
            end
            if (dev_reset) begin
                holds_reg <= 1'b0;
                stat_pend_reg <= 1'b0;
                first_done_reg <= 1'b0;
                half_reg <= 3'h0;
                stat_mask_reg <= 10'h000;
            end
        end
    end

endmodule // bln_top

// ### testbench/bln_top_sva.sv
// Checker of the balloon queue block, watching its top-level ports
`include "bln_defs.vh"
module bln_top_sva (
    input wire mclk_in,
    input wire nrst_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] prdata_out,
    input wire pready_out,
    input wire pslverr_out,
    input wire [31:0] host_req_pages_in,
    input wire avail_valid_in,
    input wire [1:0] avail_queue_in,
    input wire [31:0] avail_word_in,
    input wire avail_last_in,
    input wire [15:0] avail_desc_in,
    input wire avail_ready_out,
    input wire used_valid_out,
    input wire [1:0] used_queue_out,
    input wire [15:0] used_desc_out,
    input wire used_ready_in,
    input wire page_valid_out,
    input wire page_inflate_out,
    input wire [31:0] page_pfn_out,
    input wire [31:0] reported_pages_out,
    input wire reported_update_out,
    input wire [2:0] negotiated_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    wire acc = psel_in && penable_in;
    wire rep_wr = acc && pwrite_in && paddr_in == `BLN_OFF_REP_PAGES;
    wire stat_wr = acc && pwrite_in && paddr_in == `BLN_OFF_STATUS;
    wire page_take = avail_valid_in && avail_ready_out && !avail_queue_in[1];
    sequence inflate_close_s;
        page_take && avail_last_in && !avail_queue_in[0] && !used_valid_out;
    endsequence
    sequence inflate_used_s;
        used_valid_out && used_queue_out == `BLN_Q_INFLATE && used_desc_out == $past(avail_desc_in);
    endsequence
    ready_const_a: assert property (pready_out) else $error("pready low");
    req_read_a: assert property (
        psel_in && !penable_in && !pwrite_in && paddr_in == `BLN_OFF_REQ_PAGES
        |=> prdata_out == $past(host_req_pages_in)) else $error("requested count misread");
    bad_addr_a: assert property (
        acc && paddr_in[1:0] == 2'h0 |-> pslverr_out == (paddr_in > `BLN_OFF_HELD_PAGES))
        else $error("slave error wrong");
    used_hold_a: assert property (
        used_valid_out && !used_ready_in
        |=> used_valid_out && $stable(used_desc_out) && $stable(used_queue_out))
        else $error("used entry dropped");
    used_queue_a: assert property (
        used_valid_out |-> used_queue_out != 2'h3 && (used_queue_out != 2'h2 || negotiated_out[1]))
        else $error("used on bad queue");
    page_take_a: assert property (
        page_take |-> ##2 page_valid_out && page_pfn_out == $past(avail_word_in, 2)
        && page_inflate_out == !$past(avail_queue_in[0], 2)) else $error("page not forwarded");
    page_cause_a: assert property (page_valid_out |-> $past(page_take, 2))
        else $error("spurious page");
    inflate_ack_a: assert property (inflate_close_s |=> inflate_used_s)
        else $error("inflate not acknowledged");
    commit_cause_a: assert property (reported_update_out |-> $past(rep_wr))
        else $error("commit without write");
    rep_still_a: assert property (!reported_update_out |-> $stable(reported_pages_out))
        else $error("reported count moved");
    neg_cause_a: assert property ($changed(negotiated_out) |-> $past(stat_wr))
        else $error("features moved without status write");
endmodule // bln_top_sva

bind bln_top bln_top_sva chk (.*);

// ### testbench/bln_drv_model.sv
// Guest driver model: posts queue buffers and takes back used entries
module bln_drv_model (
    input wire mclk_in,
    input wire avail_ready_in,
    input wire used_valid_in,
    input wire [1:0] used_queue_in,
    input wire [15:0] used_desc_in,
    output logic avail_valid_out,
    output logic [1:0] avail_queue_out,
    output logic [31:0] avail_word_out,
    output logic avail_last_out,
    output logic [15:0] avail_desc_out,
    output wire used_ready_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int stall = 0;
    int wait_cnt = 0;
    logic [17:0] used_log[$];
    initial begin
        avail_valid_out = 1'b0;
        avail_queue_out = 2'h0;
        avail_word_out = 32'h0;
        avail_last_out = 1'b0;
        avail_desc_out = 16'h0;
    end
    // A slow driver leaves a used entry waiting stall cycles
    assign used_ready_out = used_valid_in && wait_cnt >= stall;
    always @(posedge mclk_in) begin
        if (used_valid_in && used_ready_out) begin
            used_log.push_back({used_queue_in, used_desc_in});
            wait_cnt <= 0;
        end else if (used_valid_in) begin
            wait_cnt <= wait_cnt + 1;
        end
    end
    // Held until taken, so a refused word is never lost
    task automatic put(input logic [1:0] q, input logic [31:0] w, input logic l, input logic [15:0] d);
        avail_valid_out <= 1'b1;
        avail_queue_out <= q;
        avail_word_out <= w;
        avail_last_out <= l;
        avail_desc_out <= d;
        do @(posedge mclk_in); while (!avail_ready_in);
    endtask
    // Released word and descriptor lines show the inverse
    task automatic release_bus();
        avail_valid_out <= 1'b0;
        avail_word_out <= ~avail_word_out;
        avail_desc_out <= ~avail_desc_out;
        avail_last_out <= 1'b0;
        @(posedge mclk_in);
    endtask
endmodule // bln_drv_model

// ### testbench/bln_top_tb.sv
// Self-checking bench of the balloon queue block
`include "bln_defs.vh"
module bln_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0, host_req_pages_in = 32'h0001_2345;
    logic [3:0] pstrb_in = 4'h0;
    wire [31:0] prdata_out, page_pfn_out, reported_pages_out, avail_word_in;
    wire pready_out, pslverr_out, avail_valid_in, avail_last_in, avail_ready_out;
    wire used_valid_out, used_ready_in, page_valid_out, page_inflate_out, reported_update_out;
    wire [1:0] avail_queue_in, used_queue_out;
    wire [15:0] avail_desc_in, used_desc_out;
    wire [2:0] negotiated_out;
    int fail_count = 0, tests_run = 0, cyc = 0, upd_cnt = 0;
    logic [32:0] page_log[$];
    bln_top dut (.mclk_in, .nrst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .pstrb_in, .prdata_out, .pready_out, .pslverr_out, .host_req_pages_in, .avail_valid_in,
        .avail_queue_in, .avail_word_in, .avail_last_in, .avail_desc_in, .avail_ready_out,
        .used_valid_out, .used_queue_out, .used_desc_out, .used_ready_in, .page_valid_out,
        .page_inflate_out, .page_pfn_out, .reported_pages_out, .reported_update_out,
        .negotiated_out);
    bln_drv_model drv (.mclk_in, .avail_ready_in(avail_ready_out), .used_valid_in(used_valid_out),
        .used_queue_in(used_queue_out), .used_desc_in(used_desc_out),
        .avail_valid_out(avail_valid_in), .avail_queue_out(avail_queue_in),
        .avail_word_out(avail_word_in), .avail_last_out(avail_last_in),
        .avail_desc_out(avail_desc_in), .used_ready_out(used_ready_in));
    always #2 mclk_in = ~mclk_in;
    always @(posedge mclk_in) begin
        if (page_valid_out) page_log.push_back({page_inflate_out, page_pfn_out});
        if (reported_update_out) upd_cnt++;
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            $display("ERROR %0t run did not finish", $time);
            conclude();
        end
    end
    task automatic conclude();
        $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // An idle cycle follows each transfer
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] rd, output logic err);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        pstrb_in <= s;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        do @(posedge mclk_in); while (!pready_out);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge mclk_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        logic [31:0] rd;
        logic e;
        apb(1'b1, a, d, s, rd, e);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic e;
        apb(1'b0, a, 32'h0, 4'h0, rd, e);
        chk(rd, exp, "register read");
        chk(e, a > `BLN_OFF_HELD_PAGES, "slave error");
    endtask
    task automatic wait_used(input int n);
        for (int i = 0; i < 100 && drv.used_log.size() < n; i++) @(posedge mclk_in);
        chk(drv.used_log.size(), n, "used count");
    endtask
    task automatic t_regs();
        rchk(`BLN_OFF_REQ_PAGES, 32'h0001_2345);
        rchk(`BLN_OFF_REP_PAGES, 32'h0);
        rchk(`BLN_OFF_DEV_FEAT, 32'h7);
        wr(`BLN_OFF_REQ_PAGES, 32'hdead_beef);
        rchk(`BLN_OFF_REQ_PAGES, 32'h0001_2345);
        rchk(8'h30, 32'h0);
    endtask
    task automatic t_negotiate();
        wr(`BLN_OFF_DRV_FEAT, 32'h6);
        wr(`BLN_OFF_STATUS, 32'hb);
        rchk(`BLN_OFF_STATUS, 32'h3);
        chk(negotiated_out, 32'h0, "refused features");
        wr(`BLN_OFF_STATUS, 32'h0);
        wr(`BLN_OFF_DRV_FEAT, 32'h7);
        wr(`BLN_OFF_STATUS, 32'hb);
        rchk(`BLN_OFF_STATUS, 32'hb);
        chk(negotiated_out, 32'h7, "accepted features");
    endtask
    task automatic t_pages();
        logic [32:0] ep[4] = '{{1'b1, 32'h10000}, {1'b1, 32'h10001}, {1'b1, 32'h20000},
                               {1'b0, 32'h10001}};
        logic [17:0] eu[3] = '{{2'h0, 16'h5}, {2'h0, 16'h6}, {2'h1, 16'h7}};
        drv.stall = 3;
        drv.put(`BLN_Q_INFLATE, 32'h10000, 1'b0, 16'h0);
        drv.put(`BLN_Q_INFLATE, 32'h10001, 1'b1, 16'h5);
        drv.put(`BLN_Q_INFLATE, 32'h20000, 1'b1, 16'h6);
        drv.put(`BLN_Q_DEFLATE, 32'h10001, 1'b1, 16'h7);
        drv.release_bus();
        wait_used(3);
        drv.stall = 0;
        for (int i = 0; i < 3; i++) chk(drv.used_log[i], eu[i], "used entry");
        chk(page_log.size(), 4, "page count");
        for (int i = 0; i < 4; i++) chk(page_log[i][31:0], ep[i][31:0], "page number");
        for (int i = 0; i < 4; i++) chk(page_log[i][32], ep[i][32], "page direction");
        rchk(`BLN_OFF_HELD_PAGES, 32'h2);
    endtask
    task automatic t_reported();
        wr(`BLN_OFF_REP_PAGES, 32'h3);
        @(posedge mclk_in);
        chk(reported_pages_out, 32'h3, "reported count");
        chk(upd_cnt, 1, "commit pulses");
        wr(`BLN_OFF_CTRL, 32'h1f);
        for (int i = 0; i < 3; i++) begin
            wr(`BLN_OFF_REP_PAGES, 32'h1122_3344, 4'h1 << i);
            chk(reported_pages_out, 32'h3, "partial write");
        end
        wr(`BLN_OFF_REP_PAGES, 32'h1122_3344, 4'h8);
        @(posedge mclk_in);
        chk(reported_pages_out, 32'h1122_3344, "legacy commit");
        chk(upd_cnt, 2, "commit pulses");
        rchk(`BLN_OFF_REP_PAGES, 32'h1122_3344);
    endtask
    function automatic logic [63:0] sval(input logic [15:0] t);
        return {16'h5a00 + t, 16'hbeef, 16'hc0de, t};
    endfunction
    // Tag halfword first, then the value from its low half up
    task automatic entry(input logic [15:0] t, input logic [63:0] v, input logic l, input logic [15:0] d);
        for (int h = 0; h < 5; h++)
            drv.put(`BLN_Q_REPORT, {16'h0, h == 0 ? t : v[16 * (h - 1) +: 16]}, l && h == 4, d);
    endtask
    task automatic t_stats();
        wr(`BLN_OFF_STATUS, 32'hf);
        entry(16'h4, 64'h77, 1'b1, 16'ha);
        drv.release_bus();
        wr(`BLN_OFF_STAT_SEL, 32'h4);
        rchk(`BLN_OFF_STAT_LO, 32'h0);
        wr(`BLN_OFF_CTRL, 32'h3f);
        wait_used(4);
        chk(drv.used_log[3], {2'h2, 16'ha}, "report used");
        entry(16'h00aa, 64'h1, 1'b0, 16'h0);
        for (int t = 9; t >= 0; t--) entry(t[15:0], sval(t[15:0]), t == 0, 16'hb);
        drv.release_bus();
        for (int t = 0; t < 10; t++) begin
            wr(`BLN_OFF_STAT_SEL, t);
            rchk(`BLN_OFF_STAT_LO, sval(t[15:0]));
            rchk(`BLN_OFF_STAT_HI, sval(t[15:0]) >> 32);
        end
        rchk(`BLN_OFF_STAT_INFO, 32'h17ff);
    endtask
    initial begin
        repeat (12) @(posedge mclk_in);
        nrst_in <= 1'b1;
        @(posedge mclk_in);
        t_regs();
        t_negotiate();
        t_pages();
        t_reported();
        t_stats();
        conclude();
    end
endmodule // bln_top_tb
